// >>> common/cpr_consts.vh
// cpr_consts.vh: constants of the card parameter record block
// assumes: included by bare name from the design files
`ifndef CPR_CONSTS_VH
`define CPR_CONSTS_VH

// ------------------------------------------------------------
// record field values
// ------------------------------------------------------------
`define CPR_LAYOUT_VERSION      2'h1
`define CPR_PROTOCOL_VERSION    4'h2
`define CPR_ASYNC_ACCESS_CODE   8'h0E
`define CPR_CLOCKED_ACCESS_CODE 8'h01
`define CPR_TRANSFER_RATE_CODE  8'h2A
`define CPR_CLASS_MASK          12'h0FF
`define CPR_READ_BLK_CODE       4'h9
`define CPR_WRITE_BLK_CODE      4'h9
`define CPR_PARTIAL_READ        1'h1
`define CPR_WRITE_CROSS         1'h0
`define CPR_READ_CROSS          1'h0
`define CPR_DRIVER_STAGE        1'h0

// ------------------------------------------------------------
// field positions in the 128-bit record
// ------------------------------------------------------------
`define CPR_POS_LAYOUT      126
`define CPR_POS_PROTOCOL    122
`define CPR_POS_ASYNC       112
`define CPR_POS_CLOCKED     104
`define CPR_POS_RATE        96
`define CPR_POS_CLASS       84
`define CPR_POS_READ_LEN    80
`define CPR_POS_PARTIAL     79
`define CPR_POS_WR_CROSS    78
`define CPR_POS_RD_CROSS    77
`define CPR_POS_DRIVER      76
`define CPR_POS_WRITE_LEN   22
`define CPR_POS_USER        8
`define CPR_POS_CRC         1

// ------------------------------------------------------------
// sub-field positions, limits, reset values and timing
// ------------------------------------------------------------
`define CPR_EXP_LSB         0
`define CPR_EXP_MSB         2
`define CPR_MANT_LSB        3
`define CPR_MANT_MSB        6
`define CPR_RSVD_BIT        7
`define CPR_RATE_EXP_MAX    3'h3
`define CPR_CYCLES_PER_UNIT 15'h064
`define CPR_BLK_LEN_RESET   12'h200
`define CPR_MAX_BLK_CODE    4'hB
`define CPR_USER_RESET      8'h00
`define CPR_ASYNC_TIME_NS   1000000
`define CPR_CLK_PERIOD_NS   25

`endif

// >>> hdl/cpr_sync.v
// cpr_sync.v: two-flip-flop synchroniser for one level
// assumes: input comes from outside the clk_i domain
`timescale 1ns/10ps
`default_nettype none

module cpr_sync
(
    // clock and reset
    input  wire clk_i,
    input  wire arst_n_i,
    // level in and out
    input  wire d_i,
    output wire q_o
);

reg meta_r;
reg sync_r;

always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
    end
    else
    begin
        meta_r <= d_i;
        sync_r <= meta_r;
    end
end

assign q_o = sync_r;

endmodule
`default_nettype wire

// >>> hdl/cpr_record.v
// cpr_record.v: card parameter record with transfer checks
// assumes: link clock and read strobes arrive from outside clk_i;
// the host computes total access time and sets the block length
`timescale 1ns/10ps
`include "cpr_consts.vh"
`default_nettype none

module cpr_record
#(
    parameter ADDR_W = 32
)
(
    // clock and reset
    input  wire              clk_i,
    input  wire              arst_n_i,
    // serial record readout on the link clock
    input  wire              link_clk_i,
    input  wire              rd_start_i,
    output reg               rd_bit_o,
    output reg               rd_busy_o,
    // user field programming
    input  wire              user_wr_i,
    input  wire [7:0]        user_data_i,
    input  wire [6:0]        user_crc_i,
    // block length selection
    input  wire              set_len_i,
    input  wire [11:0]       set_len_val_i,
    output reg  [11:0]       blk_len_o,
    output reg               len_err_o,
    // transfer check
    input  wire              xfer_chk_i,
    input  wire              xfer_wr_i,
    input  wire [ADDR_W-1:0] xfer_addr_i,
    output reg               xfer_ok_o,
    output reg               xfer_err_o,
    // decoded record values
    output wire [127:0]      record_o,
    output wire [14:0]       clocked_cycles_o,
    output wire [11:0]       max_read_len_o
);

// ------------------------------------------------------------
// state
// ------------------------------------------------------------
localparam ST_IDLE  = 2'b01;
localparam ST_SHIFT = 2'b10;

localparam [11:0] WR_BLK_LEN = 12'h001 << `CPR_WRITE_BLK_CODE;

reg  [1:0]  state_r;
reg  [1:0]  state_nxt;
reg  [6:0]  bit_idx_r;
reg  [6:0]  bit_idx_nxt;
reg  [7:0]  user_r;
reg  [6:0]  crc_r;
reg         link_d_r;
wire        link_s;
wire        start_s;
reg         start_d_r;
wire        link_rise;
wire        start_rise;
wire [11:0] rd_max_len;
wire [ADDR_W-1:0] last_addr;
wire [ADDR_W-1:0] wr_last;
wire [ADDR_W-1:0] len_ext;

// ------------------------------------------------------------
// synchronisers
// ------------------------------------------------------------
cpr_sync u_sync_clk
(
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (link_clk_i),
    .q_o      (link_s)
);

cpr_sync u_sync_start
(
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (rd_start_i),
    .q_o      (start_s)
);

always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        link_d_r  <= 1'b0;
        start_d_r <= 1'b0;
    end
    else
    begin
        link_d_r  <= link_s;
        start_d_r <= start_s;
    end
end

assign link_rise  = link_s & ~link_d_r;
assign start_rise = start_s & ~start_d_r;

// ------------------------------------------------------------
// record assembly
// ------------------------------------------------------------
assign record_o[127:126] = `CPR_LAYOUT_VERSION;
assign record_o[125:122] = `CPR_PROTOCOL_VERSION;
assign record_o[121:120] = 2'h0;
// exponent 6 with mantissa 1, top bit clear
assign record_o[119:112] = `CPR_ASYNC_ACCESS_CODE
                           & 8'h7F;
assign record_o[111:104] = `CPR_CLOCKED_ACCESS_CODE;
assign record_o[103:96]  = `CPR_TRANSFER_RATE_CODE
                           & 8'h7F;
assign record_o[95:84]   = `CPR_CLASS_MASK;
assign record_o[83:80]   = `CPR_READ_BLK_CODE;
assign record_o[79]      = `CPR_PARTIAL_READ;
assign record_o[78]      = `CPR_WRITE_CROSS;
assign record_o[77]      = `CPR_READ_CROSS;
// no driver stage register exists, so flag stays clear
assign record_o[76]      = `CPR_DRIVER_STAGE;
assign record_o[75:74]   = 2'h0;
assign record_o[73:26]   = 48'h0;
assign record_o[25:22]   = `CPR_WRITE_BLK_CODE;
assign record_o[21:16]   = 6'h0;
assign record_o[15:8]    = user_r;
assign record_o[7:1]     = crc_r;
assign record_o[0]       = 1'b1;

// ------------------------------------------------------------
// decoded values
// ------------------------------------------------------------
assign clocked_cycles_o = `CPR_CYCLES_PER_UNIT
                          * {7'h0, `CPR_CLOCKED_ACCESS_CODE};
assign rd_max_len  = 12'h001 << `CPR_READ_BLK_CODE;
assign max_read_len_o = rd_max_len;

// ------------------------------------------------------------
// user fields
// ------------------------------------------------------------
always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        user_r <= `CPR_USER_RESET;
        crc_r  <= 7'h00;
    end
    else if (user_wr_i)
    begin
        user_r <= user_data_i;
        crc_r  <= user_crc_i;
    end
end

// ------------------------------------------------------------
// block length selection
// ------------------------------------------------------------
always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        blk_len_o <= `CPR_BLK_LEN_RESET;
        len_err_o <= 1'b0;
    end
    else if (set_len_i)
    begin
        // partial reads allowed: any length 1..maximum
        if (set_len_val_i != 12'h000
            && (`CPR_PARTIAL_READ ? set_len_val_i <= rd_max_len
                : set_len_val_i == rd_max_len))
        begin
            blk_len_o <= set_len_val_i;
            len_err_o <= 1'b0;
        end
        else
        begin
            len_err_o <= 1'b1;
        end
    end
end

// ------------------------------------------------------------
// boundary check
// ------------------------------------------------------------
assign len_ext   = {{(ADDR_W-12){1'b0}}, blk_len_o} - 1'b1;
assign last_addr = xfer_addr_i + len_ext;
assign wr_last   = xfer_addr_i
                   + {{(ADDR_W-12){1'b0}}, WR_BLK_LEN - 12'h001};

always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        xfer_ok_o  <= 1'b0;
        xfer_err_o <= 1'b0;
    end
    else
    begin
        xfer_ok_o  <= 1'b0;
        xfer_err_o <= 1'b0;
        if (xfer_chk_i)
        begin
            if (xfer_wr_i)
            begin
                if (`CPR_WRITE_CROSS == 1'b0
                    && (wr_last[ADDR_W-1:9]
                        != xfer_addr_i[ADDR_W-1:9]))
                    xfer_err_o <= 1'b1;
                else
                    xfer_ok_o  <= 1'b1;
            end
            else
            begin
                if (`CPR_READ_CROSS == 1'b0
                    && (last_addr[ADDR_W-1:9]
                        != xfer_addr_i[ADDR_W-1:9]))
                    xfer_err_o <= 1'b1;
                else
                    xfer_ok_o  <= 1'b1;
            end
        end
    end
end

// ------------------------------------------------------------
// serial readout
// ------------------------------------------------------------
always @*
begin
    state_nxt   = state_r;
    bit_idx_nxt = bit_idx_r;
    case (state_r)
        ST_IDLE:
        begin
            if (start_rise)
            begin
                state_nxt   = ST_SHIFT;
                bit_idx_nxt = 7'h7F;
            end
        end
        ST_SHIFT:
        begin
            if (link_rise)
            begin
                if (bit_idx_r == 7'h00)
                    state_nxt = ST_IDLE;
                else
                    bit_idx_nxt = bit_idx_r - 7'h01;
            end
        end
        default:
        begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        state_r   <= ST_IDLE;
        bit_idx_r <= 7'h00;
        rd_bit_o  <= 1'b0;
        rd_busy_o <= 1'b0;
    end
    else
    begin
        state_r   <= state_nxt;
        bit_idx_r <= bit_idx_nxt;
        rd_busy_o <= (state_nxt == ST_SHIFT);
        rd_bit_o  <= (state_nxt == ST_SHIFT)
                     ? record_o[bit_idx_nxt] : 1'b0;
    end
end

endmodule
`default_nettype wire

// >>> dv/cpr_record_sva.sv
// cpr_record_sva.sv: checker for the card parameter record
// assumes: bound to cpr_record, sees only its ports
`timescale 1ns/10ps
`default_nettype none
module cpr_record_sva
#(
    parameter ADDR_W = 32
)
(
    // clock and reset
    input wire logic              clk_i,
    input wire logic              arst_n_i,
    // control inputs
    input wire logic              user_wr_i,
    input wire logic [7:0]        user_data_i,
    input wire logic [6:0]        user_crc_i,
    input wire logic              set_len_i,
    input wire logic [11:0]       set_len_val_i,
    input wire logic              xfer_chk_i,
    input wire logic              xfer_wr_i,
    input wire logic [ADDR_W-1:0] xfer_addr_i,
    // outputs watched
    input wire logic [11:0]       blk_len_o,
    input wire logic              len_err_o,
    input wire logic              xfer_ok_o,
    input wire logic              xfer_err_o,
    input wire logic              rd_busy_o,
    input wire logic [127:0]      record_o,
    input wire logic [14:0]       clocked_cycles_o,
    input wire logic [11:0]       max_read_len_o
);
    // ----------------------------------------------------------
    // helpers and properties
    // ----------------------------------------------------------
    wire [12:0] end_w = {4'h0, xfer_addr_i[8:0]} + {1'h0, blk_len_o};
    wire        cross_w = xfer_wr_i ? (xfer_addr_i[8:0] != 9'h000)
                                    : (end_w > 13'h0200);
    wire        ok_w = (set_len_val_i != 12'h000)
                       && (set_len_val_i <= 12'h200);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_ver; record_o[127:120] == 8'h48; endproperty
    property p_async; record_o[119:112] == 8'h0E; endproperty
    property p_nac;
        {record_o[111:104], clocked_cycles_o} == {8'h01, 15'h0064};
    endproperty
    property p_rate; record_o[103:96] == 8'h2A; endproperty
    property p_class;
        {record_o[95:80], max_read_len_o} == {16'h0FF9, 12'h200};
    endproperty
    property p_flags; record_o[79:74] == 6'h20; endproperty
    property p_user;
        user_wr_i |=> record_o[15:1] == {$past(user_data_i),
                                         $past(user_crc_i)};
    endproperty
    property p_len;
        set_len_i |=> (len_err_o == !$past(ok_w)) && (blk_len_o ==
            ($past(ok_w) ? $past(set_len_val_i) : $past(blk_len_o)));
    endproperty
    property p_xfer;
        xfer_chk_i |=> {xfer_err_o, xfer_ok_o} ==
                       {$past(cross_w), !$past(cross_w)};
    endproperty
    a_ver: assert property (p_ver)
        else $error("version fields wrong");
    a_async: assert property (p_async)
        else $error("async access code wrong");
    a_nac: assert property (p_nac)
        else $error("clocked access code wrong");
    a_rate: assert property (p_rate)
        else $error("rate code wrong");
    a_class: assert property (p_class)
        else $error("class mask or read length wrong");
    a_flags: assert property (p_flags)
        else $error("flag bits wrong");
    a_user: assert property (p_user)
        else $error("user field not loaded");
    a_len: assert property (p_len)
        else $error("block length handling wrong");
    a_xfer: assert property (p_xfer)
        else $error("transfer check wrong");
    c_err: cover property (xfer_err_o);
    c_len: cover property (len_err_o);
    c_rd: cover property ($fell(rd_busy_o));
endmodule
bind cpr_record cpr_record_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// >>> dv/cpr_host_model.sv
// cpr_host_model.sv: host side of the serial record readout
// assumes: link clock idles low between frames, 200 ns period
`timescale 1ns/10ps
`default_nettype none
module cpr_host_model
(
    // clock
    input  wire logic         clk_i,
    // readout lines
    input  wire logic         rd_bit_i,
    input  wire logic         rd_busy_i,
    output var  logic         link_clk_o,
    output var  logic         rd_start_o,
    output var  logic [127:0] got_o,
    output wire logic [14:0]  acc_cyc_o
);
    // ----------------------------------------------------------
    // frame reader
    // ----------------------------------------------------------
    initial
    begin
        link_clk_o = 1'b0;
        rd_start_o = 1'b0;
        got_o = 128'h0;
    end
    // clocked part of the total access time
    assign acc_cyc_o = 15'h0064 * {7'h00, got_o[111:104]};
    task read_rec;
        int i;
        @(negedge clk_i);
        rd_start_o = 1'b1;
        for (i = 0; i < 40 && rd_busy_i !== 1'b1; i++)
            @(negedge clk_i);
        for (i = 127; i >= 0; i--)
        begin
            #50 got_o[i] = rd_bit_i;
            #50 link_clk_o = 1'b1;
            #100 link_clk_o = 1'b0;
        end
        rd_start_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> dv/cpr_record_tb.sv
// cpr_record_tb.sv: self-checking bench for cpr_record
// assumes: host model drives the link clock and readout start
`timescale 1ns/10ps
`default_nettype none
module cpr_record_tb;
    logic         clk_i, arst_n_i, link_clk, rd_start, rd_bit, rd_busy;
    logic         user_wr_i, set_len_i, xfer_chk_i, xfer_wr_i;
    logic         len_err_o, xfer_ok_o, xfer_err_o;
    logic [7:0]   user_data_i;
    logic [6:0]   user_crc_i;
    logic [11:0]  set_len_val_i, blk_len_o, max_read_len_o;
    logic [31:0]  xfer_addr_i;
    logic [127:0] record_o, got;
    logic [14:0]  clocked_cycles_o, acc_cyc;
    int           num_errors, checked, i;
    logic [51:0]  fix = {2'h1, 4'h2, 2'h0, 8'h0E, 8'h01, 8'h2A,
                         12'h0FF, 4'h9, 4'h8};
    logic [11:0]  lv [5] = '{12'h001, 12'h000, 12'h200, 12'h201, 12'h064};
    logic [12:0]  le [5] = '{13'h0001, 13'h1001, 13'h0200, 13'h1200,
                             13'h0064};
    logic [11:0]  xa [6] = '{12'h1F0, 12'h19C, 12'h000, 12'h200,
                             12'h201, 12'h3FF};
    logic [1:0]   xe [6] = '{2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
    // ----------------------------------------------------------
    // instances and tasks
    // ----------------------------------------------------------
    cpr_record dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .link_clk_i(link_clk), .rd_start_i(rd_start), .rd_bit_o(rd_bit),
        .rd_busy_o(rd_busy), .user_wr_i(user_wr_i),
        .user_data_i(user_data_i), .user_crc_i(user_crc_i),
        .set_len_i(set_len_i), .set_len_val_i(set_len_val_i),
        .blk_len_o(blk_len_o), .len_err_o(len_err_o),
        .xfer_chk_i(xfer_chk_i), .xfer_wr_i(xfer_wr_i),
        .xfer_addr_i(xfer_addr_i), .xfer_ok_o(xfer_ok_o),
        .xfer_err_o(xfer_err_o), .record_o(record_o),
        .clocked_cycles_o(clocked_cycles_o),
        .max_read_len_o(max_read_len_o));
    cpr_host_model u_host (.clk_i(clk_i), .rd_bit_i(rd_bit),
        .rd_busy_i(rd_busy), .link_clk_o(link_clk), .rd_start_o(rd_start),
        .got_o(got), .acc_cyc_o(acc_cyc));
    task check(input logic [127:0] g, input logic [127:0] e);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task pulse(input int k);
        @(negedge clk_i);
        {user_wr_i, set_len_i, xfer_chk_i} = 3'h1 << k;
        @(negedge clk_i);
        {user_wr_i, set_len_i, xfer_chk_i} = 3'h0;
        @(negedge clk_i);
    endtask
    task finish_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial
    begin
        #200000;
        num_errors++;
        finish_test;
    end
    initial
    begin
        {arst_n_i, user_wr_i, set_len_i, xfer_chk_i, xfer_wr_i} = 5'h0;
        {user_data_i, user_crc_i, set_len_val_i, xfer_addr_i} = 59'h0;
        num_errors = 0;
        checked = 0;
        repeat (9) @(negedge clk_i);
        arst_n_i = 1'b1;
        check({len_err_o, blk_len_o}, 13'h0200);
        check(record_o[127:76], fix);
        check({clocked_cycles_o, max_read_len_o}, 27'h0064200);
        user_data_i = 8'hA5;
        user_crc_i = 7'h5A;
        pulse(2);
        check(record_o[15:1], 15'h52DA);
        check(record_o[127:76], fix);
        for (i = 0; i < 5; i++)
        begin
            set_len_val_i = lv[i];
            pulse(1);
            check({len_err_o, blk_len_o}, le[i]);
        end
        for (i = 0; i < 6; i++)
        begin
            xfer_wr_i = (i > 2);
            xfer_addr_i = {20'h00000, xa[i]};
            @(negedge clk_i);
            xfer_chk_i = 1'b1;
            @(negedge clk_i);
            xfer_chk_i = 1'b0;
            check({xfer_err_o, xfer_ok_o}, xe[i]);
        end
        u_host.read_rec();
        check(got, {fix, 50'h0, 4'h9, 6'h0,
                    15'h52DA, 1'b1});
        check(acc_cyc, 15'h0064);
        repeat (8) @(negedge clk_i);
        check(rd_busy, 1'b0);
        arst_n_i = 1'b0;
        @(negedge clk_i);
        arst_n_i = 1'b1;
        check({blk_len_o, record_o[15:1]}, 27'h1000000);
        finish_test;
    end
endmodule
`default_nettype wire
